// >>> cts_pkg.sv
// Shared constants and carrier types for the charge termination sequencer.
// Assumes a 10 MHz system clock and an AHB-Lite register port.
package cts_pkg;

	// Clock and oscillator timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int OSC_PERIOD_NS = 7630;
	localparam int OSC_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int OSC_CNT_W = 7;

	// Shared counter chain and the tap that paces the long timers
	localparam int CHAIN_W = 25;
	localparam int TAP_BIT = 8;
	localparam longint TAP_PERIOD_NS = longint'(OSC_PERIOD_NS) * (64'd1 << TAP_BIT);

	// Time-outs and filters, as printed
	localparam longint PRE_TIME_S = 1;
	localparam longint PRE_TIME_MIN = 60;
	localparam longint CHG_TIME_H = 3;
	localparam longint REMOVAL_TIME_US = 859000;
	localparam longint TAPER_TIME_US = 3500000;
	localparam int PRE_TAPS = int'(PRE_TIME_S * PRE_TIME_MIN * 60 * 64'd1000000000 / TAP_PERIOD_NS);
	localparam int CHG_TAPS = int'(CHG_TIME_H * 3600 * 64'd1000000000 / TAP_PERIOD_NS);
	localparam int REMOVAL_TICKS = int'(REMOVAL_TIME_US * 1000 / OSC_PERIOD_NS);
	localparam int TAPER_TICKS = int'(TAPER_TIME_US * 1000 / OSC_PERIOD_NS);
	localparam int TMR_W = 32;

	// Register map (byte offsets)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_CHAIN = 8'h08;
	localparam logic [7:0] REG_PRE_TMR = 8'h0C;
	localparam logic [7:0] REG_CHG_TMR = 8'h10;
	localparam int CTRL_RESET_BIT = 0;
	localparam int CTRL_TEST_BIT = 1;
	localparam logic [1:0] CTRL_RST_VAL = 2'h0;

	// Comparator flags after digitisation
	typedef struct packed {
		logic battery_high_flag;
		logic battery_low_flag;
		logic taper_flag;
		logic cold_flag;
		logic hot_flag;
		logic thermistor_reset_flag;
		logic supply_undervoltage_flag;
	} cts_flags_t;
	localparam cts_flags_t FLAGS_RST = 7'h01;

	// Pin and source controls
	typedef struct packed {
		logic charger_off_oe_n;
		logic status_hard_oe_n;
		logic status_soft_en;
		logic trickle_en;
		logic charge_src_en;
		logic sense_sink_en;
		logic divider_connect;
	} cts_drive_t;
	localparam cts_drive_t DRIVE_RST = 7'h60;

	typedef enum logic [2:0] {
		ST_PRECOND,
		ST_ON,
		ST_PAUSE,
		ST_DONE,
		ST_NOBAT
	} cts_state_t;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// >>> cts_sequencer.sv
// Logic and timer core of the charge termination controller, with registers.
// Assumes asynchronous comparator flags and an AHB-Lite master on hclk.
//
// Notes on behaviour
// - Oscillator tick near 7.63 us, 25-stage chain
// - Precondition ends after one hour timer
// - Charger stopped after three hours charging
// - Short battery-high blips ignored, timers kept
// - Taper flag accepted after 3.5 s filter
// - Battery-high flag marks pack removal
// - Battery-low flag starts trickle preconditioning
// - Trickle source in precondition, small in charge
// - Sources off in idle states, hold, reset
// - Sense sink only in the precondition and charge states
// - Thermistor out of range freezes state, timers
// - Hold stops charger, sources; status kept
// - Thermistor reset clears timers, forces charge
// - Reset mode pulls status low except on undervoltage, sources off
// - Power-up starts in reset mode
// - Undervoltage shuts down, divider disconnected
// - Hard status pull-down, soft after taper
// - Charger-off released to run, low stops
// - Battery-high while charging clamps charger-off
// - On to pause; pause resolves after filter
// - Done leaves only to no-battery, or to charge in reset mode
// - No-battery to charge after filter low
// - Precondition timeout to done; low returns
`timescale 1ns/10ps
`default_nettype none

module cts_sequencer #(
	parameter int PRE_TAPS = cts_pkg::PRE_TAPS,
	parameter int CHG_TAPS = cts_pkg::CHG_TAPS,
	parameter int REMOVAL_TICKS = cts_pkg::REMOVAL_TICKS,
	parameter int TAPER_TICKS = cts_pkg::TAPER_TICKS
)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire cts_pkg::cts_flags_t flags_async,
	output cts_pkg::cts_drive_t drive,
	output logic charger_off_out,
	output logic status_out
);

	logic [6:0] sync1;
	logic [6:0] sync2;
	logic [6:0] sync3;
	cts_pkg::cts_flags_t flg;
	logic [cts_pkg::OSC_CNT_W-1:0] osc_cnt;
	logic osc_tick;
	logic tick;
	logic tap_tick;
	logic [cts_pkg::CHAIN_W-1:0] chain;
	logic [cts_pkg::TMR_W-1:0] pre_timer;
	logic [cts_pkg::TMR_W-1:0] chg_timer;
	logic [cts_pkg::TMR_W-1:0] rem_cnt;
	logic [cts_pkg::TMR_W-1:0] taper_cnt;
	logic rem_level;
	logic rem_done;
	logic taper_done;
	logic powerup;
	logic [1:0] ctrl;
	logic reset_mode;
	logic hold_mode;
	logic run;
	cts_pkg::cts_state_t state;
	cts_pkg::cts_state_t next_state;
	logic in_charge;
	logic pre_timeout;
	logic chg_timeout;
	logic wr_pend;
	logic [7:0] wr_addr;

	assign charger_off_out = 1'b0;
	assign status_out = 1'b0;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Three-stage synchroniser; a bit changes when stages two and three agree
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1 <= cts_pkg::FLAGS_RST;
			sync2 <= cts_pkg::FLAGS_RST;
			sync3 <= cts_pkg::FLAGS_RST;
			flg <= cts_pkg::FLAGS_RST;
		end
		else
		begin
			sync1 <= flags_async;
			sync2 <= sync1;
			sync3 <= sync2;
			flg <= (sync3 & ~(sync2 ^ sync3)) | (flg & (sync2 ^ sync3));
		end
	end

	// Power-up pulse: one cycle of reset mode after release
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			powerup <= 1'b1;
		else
			powerup <= 1'b0;
	end

	assign reset_mode = powerup || flg.supply_undervoltage_flag || flg.thermistor_reset_flag
		|| ctrl[cts_pkg::CTRL_RESET_BIT];
	assign hold_mode = !reset_mode && (flg.cold_flag || flg.hot_flag);
	assign run = !reset_mode && !hold_mode;

	// Oscillator divider
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			osc_cnt <= '0;
		else if (osc_tick)
			osc_cnt <= '0;
		else
			osc_cnt <= osc_cnt + 1'b1;
	end
	assign osc_tick = (osc_cnt == cts_pkg::OSC_CYCLES[cts_pkg::OSC_CNT_W-1:0] - 1'b1);
	assign tick = osc_tick || ctrl[cts_pkg::CTRL_TEST_BIT];
	assign tap_tick = tick && (&chain[cts_pkg::TAP_BIT-1:0]);

	// Shared chain, cleared in reset mode, frozen in hold
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			chain <= '0;
		else if (reset_mode)
			chain <= '0;
		else if (run && tick)
			chain <= chain + 1'b1;
	end

	// Long timers paced by the chain tap
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pre_timer <= '0;
			chg_timer <= '0;
		end
		else if (reset_mode || (run && state == cts_pkg::ST_NOBAT))
		begin
			pre_timer <= '0;
			chg_timer <= '0;
		end
		else if (run && tap_tick)
		begin
			if (state == cts_pkg::ST_PRECOND && !pre_timeout)
				pre_timer <= pre_timer + 1'b1;
			if (state == cts_pkg::ST_ON && !chg_timeout)
				chg_timer <= chg_timer + 1'b1;
		end
	end
	assign pre_timeout = (pre_timer >= PRE_TAPS);
	assign chg_timeout = (chg_timer >= CHG_TAPS);

	// Removal filter: restarts on every change of the battery-high level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rem_cnt <= '0;
			rem_level <= 1'b0;
		end
		else if (reset_mode || flg.battery_high_flag != rem_level)
		begin
			rem_cnt <= '0;
			rem_level <= flg.battery_high_flag;
		end
		else if (run && tick && !rem_done)
			rem_cnt <= rem_cnt + 1'b1;
	end
	assign rem_done = (rem_cnt >= REMOVAL_TICKS);

	// Taper filter and its sticky result
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			taper_cnt <= '0;
			taper_done <= 1'b0;
		end
		else if (reset_mode || (run && state == cts_pkg::ST_NOBAT))
		begin
			taper_cnt <= '0;
			taper_done <= 1'b0;
		end
		else if (!flg.taper_flag || state != cts_pkg::ST_ON)
			taper_cnt <= '0;
		else if (run && tick && !taper_done)
		begin
			if (taper_cnt == TAPER_TICKS - 1)
				taper_done <= 1'b1;
			taper_cnt <= taper_cnt + 1'b1;
		end
	end

	// State transitions
	always_comb
	begin
		next_state = state;
		case (state)
			cts_pkg::ST_PRECOND:
			begin
				if (pre_timeout)
					next_state = cts_pkg::ST_DONE;
				else if (!flg.battery_low_flag)
					next_state = cts_pkg::ST_ON;
			end
			cts_pkg::ST_ON:
			begin
				if (chg_timeout)
					next_state = cts_pkg::ST_DONE;
				else if (flg.battery_high_flag)
					next_state = cts_pkg::ST_PAUSE;
				else if (flg.battery_low_flag)
					next_state = cts_pkg::ST_PRECOND;
			end
			cts_pkg::ST_PAUSE:
			begin
				if (rem_done && rem_level)
					next_state = cts_pkg::ST_NOBAT;
				else if (rem_done && !rem_level)
					next_state = cts_pkg::ST_ON;
			end
			cts_pkg::ST_DONE:
			begin
				if (rem_done && rem_level)
					next_state = cts_pkg::ST_NOBAT;
			end
			cts_pkg::ST_NOBAT:
			begin
				if (rem_done && !rem_level)
					next_state = flg.battery_low_flag ? cts_pkg::ST_PRECOND
						: cts_pkg::ST_ON;
			end
			default:
				next_state = cts_pkg::ST_PRECOND;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state <= cts_pkg::ST_PRECOND;
		else if (reset_mode)
			state <= flg.battery_low_flag ? cts_pkg::ST_PRECOND : cts_pkg::ST_ON;
		else if (run)
			state <= next_state;
	end

	assign in_charge = (state == cts_pkg::ST_PRECOND) || (state == cts_pkg::ST_ON);

	// Registered pin and source controls
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			drive <= cts_pkg::DRIVE_RST;
		else if (flg.supply_undervoltage_flag)
			drive <= cts_pkg::DRIVE_RST;
		else if (reset_mode)
		begin
			drive.charger_off_oe_n <= 1'b0;
			drive.status_hard_oe_n <= 1'b0;
			drive.status_soft_en <= 1'b0;
			drive.trickle_en <= 1'b0;
			drive.charge_src_en <= 1'b0;
			drive.sense_sink_en <= 1'b0;
			drive.divider_connect <= 1'b1;
		end
		else if (hold_mode)
		begin
			drive.charger_off_oe_n <= 1'b0;
			drive.trickle_en <= 1'b0;
			drive.charge_src_en <= 1'b0;
			drive.sense_sink_en <= 1'b0;
			drive.divider_connect <= 1'b1;
		end
		else
		begin
			drive.charger_off_oe_n <= (state == cts_pkg::ST_ON && !flg.battery_high_flag);
			drive.status_hard_oe_n <= !(state == cts_pkg::ST_PRECOND
				|| (state != cts_pkg::ST_DONE && state != cts_pkg::ST_NOBAT && !taper_done));
			drive.status_soft_en <= (state == cts_pkg::ST_ON || state == cts_pkg::ST_PAUSE)
				&& taper_done;
			drive.trickle_en <= (state == cts_pkg::ST_PRECOND);
			drive.charge_src_en <= (state == cts_pkg::ST_ON);
			drive.sense_sink_en <= in_charge;
			drive.divider_connect <= 1'b1;
		end
	end

	// Bus slave: zero wait states, reads registered at the address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end
		else if (hready)
		begin
			wr_pend <= hsel && hwrite && htrans == cts_pkg::HTRANS_NONSEQ;
			wr_addr <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl <= cts_pkg::CTRL_RST_VAL;
		else if (wr_pend && wr_addr == cts_pkg::REG_CTRL)
			ctrl <= hwdata[1:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= '0;
		else if (hready && hsel && !hwrite && htrans == cts_pkg::HTRANS_NONSEQ)
		begin
			case (haddr[7:0])
				cts_pkg::REG_CTRL: hrdata <= {30'h0, ctrl};
				cts_pkg::REG_STAT: hrdata <= {17'h0, drive, flg.supply_undervoltage_flag,
					taper_done, hold_mode, reset_mode, 1'b0, state};
				cts_pkg::REG_CHAIN: hrdata <= {7'h0, chain};
				cts_pkg::REG_PRE_TMR: hrdata <= pre_timer;
				cts_pkg::REG_CHG_TMR: hrdata <= chg_timer;
				default: hrdata <= 32'h0;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_trickle_only_precond;
		drive.trickle_en |-> $past(state) == cts_pkg::ST_PRECOND && $past(run);
	endproperty
	a_trickle_only_precond: assert property (p_trickle_only_precond)
		else $error("trickle source on outside precondition");

	property p_hold_outputs;
		hold_mode && !flg.supply_undervoltage_flag |=> !drive.charger_off_oe_n
			&& !drive.trickle_en && !drive.charge_src_en && !drive.sense_sink_en;
	endproperty
	a_hold_outputs: assert property (p_hold_outputs)
		else $error("hold left charger or sources on");

	property p_hold_freeze;
		hold_mode ##1 hold_mode |-> $stable(state) && $stable(pre_timer) && $stable(chg_timer);
	endproperty
	a_hold_freeze: assert property (p_hold_freeze)
		else $error("state or timer moved during hold");

	property p_reset_clears;
		reset_mode |=> pre_timer == 0 && chg_timer == 0 && chain == 0 && in_charge;
	endproperty
	a_reset_clears: assert property (p_reset_clears)
		else $error("reset mode did not clear timers");

	property p_reset_status;
		reset_mode && !flg.supply_undervoltage_flag |=> !drive.status_hard_oe_n
			&& !drive.charge_src_en && !drive.sense_sink_en;
	endproperty
	a_reset_status: assert property (p_reset_status)
		else $error("reset mode outputs wrong");

	property p_uv_shutdown;
		flg.supply_undervoltage_flag |=> !drive.divider_connect && drive.charger_off_oe_n
			&& !drive.trickle_en;
	endproperty
	a_uv_shutdown: assert property (p_uv_shutdown)
		else $error("undervoltage did not shut down");

	property p_sense_in_charge;
		drive.sense_sink_en |-> $past(in_charge);
	endproperty
	a_sense_in_charge: assert property (p_sense_in_charge)
		else $error("sense sink on outside charge state");

	property p_taper_filter;
		$rose(taper_done) |-> $past(taper_cnt) == TAPER_TICKS - 1 && $past(flg.taper_flag);
	endproperty
	a_taper_filter: assert property (p_taper_filter)
		else $error("taper accepted before filter time");

	property p_on_to_pause;
		run && state == cts_pkg::ST_ON && !chg_timeout && flg.battery_high_flag
			|=> state == cts_pkg::ST_PAUSE;
	endproperty
	a_on_to_pause: assert property (p_on_to_pause)
		else $error("battery-high did not pause charging");

	property p_done_exit;
		run && state == cts_pkg::ST_DONE |=> state == cts_pkg::ST_DONE
			|| (state == cts_pkg::ST_NOBAT && $past(rem_done) && $past(rem_level));
	endproperty
	a_done_exit: assert property (p_done_exit)
		else $error("illegal exit from done");

	c_reach_done: cover property (state == cts_pkg::ST_ON ##1 state == cts_pkg::ST_DONE);
	c_reach_nobat: cover property (state == cts_pkg::ST_PAUSE ##1 state == cts_pkg::ST_NOBAT);
	c_pause_resume: cover property (state == cts_pkg::ST_PAUSE ##1 state == cts_pkg::ST_ON);
	c_taper: cover property ($rose(taper_done));

endmodule

`default_nettype wire

// >>> cts_charger_model.sv
// Behavioural model of the external switching charger on the far side.
// Assumes the sequencer's charger-off enable and a pack-present level from the bench.
`timescale 1ns/10ps
`default_nettype none

module cts_charger_model (
	input wire logic hclk,
	input wire logic charger_off_oe_n,
	input wire logic pack_present,
	output logic regulating,
	output logic battery_high
);
	// Regulates only while the charger-off pin is released
	always_ff @(posedge hclk)
	begin
		regulating <= charger_off_oe_n;
	end

	// Open terminal is pulled above the high threshold
	assign battery_high = ~pack_present;
endmodule

`default_nettype wire

// >>> cts_sequencer_tb.sv
// Self-checking bench for the charge termination sequencer.
// Assumes the design package and the charger model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module cts_sequencer_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [5:0] fl = 6'h01;
	logic pack = 1'b1;
	logic bh;
	logic reg_on;
	logic co_pin;
	logic st_pin;
	cts_pkg::cts_drive_t drive;
	logic [31:0] rd;
	logic [31:0] t0;
	int n_mismatch = 0;
	int n_tests = 0;

	always #50 hclk = ~hclk;

	cts_sequencer #(.PRE_TAPS(4), .CHG_TAPS(8), .REMOVAL_TICKS(5), .TAPER_TICKS(6)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flags_async({bh, fl}),
		.drive(drive), .charger_off_out(co_pin), .status_out(st_pin)
	);

	cts_charger_model u_chg (
		.hclk(hclk), .charger_off_oe_n(drive.charger_off_oe_n), .pack_present(pack),
		.regulating(reg_on), .battery_high(bh)
	);

	task automatic complete_run;
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= cts_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic st(input cts_pkg::cts_state_t e);
		ahb(1'b0, cts_pkg::REG_STAT, 32'h0);
		chk("state", 32'(e), rd & 32'h7);
	endtask

	// Polls the drive struct mid-cycle, then realigns to a rising edge
	task automatic expect_drv(input string nm, input logic [6:0] e, input logic [6:0] m,
		input int lo, input int hi);
		int n;
		n = 0;
		@(negedge hclk);
		while (((drive & m) !== (e & m)) && n < hi)
		begin
			@(negedge hclk);
			n++;
		end
		chk(nm, 32'(e & m), 32'(drive & m));
		chk({nm, " delay"}, 32'h1, 32'(n >= lo));
		@(posedge hclk);
	endtask

	initial
	begin
		repeat (4) @(posedge hclk);
		chk("reset drive", 32'h60, 32'(drive));
		hresetn <= 1'b1;
		ahb(1'b0, cts_pkg::REG_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		ahb(1'b1, 8'h40, 32'hFFFFFFFF);
		ahb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, 32'(hresp));
		chk("pin levels", 32'h0, 32'({co_pin, st_pin}));
		ahb(1'b1, cts_pkg::REG_CTRL, 32'h2);
		ahb(1'b0, cts_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 32'h2, rd);
		fl <= 6'h00;
		expect_drv("power-up", 7'h47, 7'h6F, 1, 20);
		st(cts_pkg::ST_ON);
		fl <= 6'h10;
		repeat (3) @(posedge hclk);
		fl <= 6'h00;
		repeat (30) @(posedge hclk);
		expect_drv("taper blip", 7'h47, 7'h6F, 0, 0);
		fl <= 6'h10;
		expect_drv("taper", 7'h77, 7'h7F, 6, 40);
		fl <= 6'h00;
		repeat (300) @(posedge hclk);
		ahb(1'b0, cts_pkg::REG_CHG_TMR, 32'h0);
		t0 = rd;
		chk("timer runs", 32'h1, 32'(rd != 32'h0));
		pack <= 1'b0;
		repeat (2) @(posedge hclk);
		pack <= 1'b1;
		expect_drv("clamp", 7'h01, 7'h4F, 0, 15);
		expect_drv("resume", 7'h77, 7'h7F, 3, 40);
		ahb(1'b0, cts_pkg::REG_CHG_TMR, 32'h0);
		chk("timer kept", 32'h1, 32'(rd >= t0));
		chk("charger running", 32'h1, 32'(reg_on));
		fl <= 6'h08;
		expect_drv("cold hold", 7'h31, 7'h7F, 0, 10);
		ahb(1'b0, cts_pkg::REG_CHG_TMR, 32'h0);
		t0 = rd;
		chk("charger idle", 32'h0, 32'(reg_on));
		repeat (600) @(posedge hclk);
		ahb(1'b0, cts_pkg::REG_CHG_TMR, 32'h0);
		chk("timer frozen", t0, rd);
		st(cts_pkg::ST_ON);
		fl <= 6'h04;
		expect_drv("hot hold", 7'h31, 7'h7F, 0, 10);
		fl <= 6'h00;
		expect_drv("hold exit", 7'h77, 7'h7F, 0, 15);
		fl <= 6'h02;
		expect_drv("reset mode", 7'h01, 7'h6F, 0, 10);
		ahb(1'b0, cts_pkg::REG_CHG_TMR, 32'h0);
		chk("charge timer clear", 32'h0, rd);
		ahb(1'b0, cts_pkg::REG_PRE_TMR, 32'h0);
		chk("pre timer clear", 32'h0, rd);
		fl <= 6'h00;
		expect_drv("restart", 7'h47, 7'h6F, 0, 15);
		st(cts_pkg::ST_ON);
		expect_drv("charge timeout", 7'h21, 7'h7F, 1700, 2500);
		st(cts_pkg::ST_DONE);
		fl <= 6'h20;
		repeat (40) @(posedge hclk);
		st(cts_pkg::ST_DONE);
		fl <= 6'h00;
		pack <= 1'b0;
		repeat (40) @(posedge hclk);
		st(cts_pkg::ST_NOBAT);
		expect_drv("no battery", 7'h21, 7'h7F, 0, 0);
		pack <= 1'b1;
		expect_drv("new battery", 7'h47, 7'h6F, 3, 40);
		pack <= 1'b0;
		repeat (40) @(posedge hclk);
		st(cts_pkg::ST_NOBAT);
		pack <= 1'b1;
		expect_drv("reinsert", 7'h47, 7'h6F, 3, 40);
		fl <= 6'h20;
		expect_drv("precondition", 7'h0B, 7'h6F, 0, 15);
		st(cts_pkg::ST_PRECOND);
		expect_drv("pre timeout", 7'h21, 7'h7F, 700, 1400);
		fl <= 6'h01;
		expect_drv("shutdown", 7'h60, 7'h7F, 0, 10);
		fl <= 6'h00;
		expect_drv("supply back", 7'h47, 7'h6F, 0, 20);
		ahb(1'b1, cts_pkg::REG_CTRL, 32'h3);
		expect_drv("forced reset", 7'h01, 7'h6F, 0, 10);
		ahb(1'b1, cts_pkg::REG_CTRL, 32'h2);
		expect_drv("forced release", 7'h47, 7'h6F, 0, 15);
		complete_run;
	end

	initial
	begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		complete_run;
	end
endmodule

`default_nettype wire
